// ===== design/alidp_logic_unit.sv
// Combinational subtract, negate and bitwise logic at byte or word width.
`timescale 1ns/100ps
module alidp_logic_unit
(
    // Operation select.
    input alidp_pkg::alidp_op_t op,
    input wire logic word_size,
    // Operands and carry.
    input wire logic [15:0] src_operand,
    input wire logic [15:0] dest_operand,
    input wire logic carry_in,
    // Results.
    output logic [15:0] logic_result,
    output logic carry_out,
    output logic overflow_out
);
    import alidp_pkg::*;

    logic [15:0] mask;
    logic is_negate;
    logic [15:0] sub_dest;
    logic [15:0] sub_src;
    logic [15:0] inv_src;
    logic borrow_cin;
    logic [16:0] diff;
    logic [15:0] diff_res;

    // Negate is zero minus destination, sharing the subtractor.
    assign mask = alidp_mask(word_size);
    assign is_negate = (op == ALIDP_OP_NEGATE_OP);
    assign sub_dest = is_negate ? 16'h0000 : (dest_operand & mask);
    assign sub_src = (is_negate ? dest_operand : src_operand) & mask;
    assign inv_src = ~sub_src & mask;
    assign borrow_cin = (op == ALIDP_OP_SUBTRACT_WITH_BORROW) ? carry_in : 1'b1;
    assign diff = {1'b0, sub_dest} + {1'b0, inv_src} + {16'h0000, borrow_cin};
    assign diff_res = diff[15:0] & mask;

    // Carry is set when no borrow occurred out of the selected width.
    assign carry_out = word_size ? diff[16] : diff[8];
    assign overflow_out = (alidp_msb(word_size, sub_dest) != alidp_msb(word_size, sub_src))
        && (alidp_msb(word_size, diff_res) != alidp_msb(word_size, sub_dest));

    // Result selection by operation.
    always_comb
    begin
        case (op)
            ALIDP_OP_AND: logic_result = src_operand & dest_operand & mask;
            ALIDP_OP_BITWISE_TEST: logic_result = src_operand & dest_operand & mask;
            ALIDP_OP_OR: logic_result = (src_operand | dest_operand) & mask;
            ALIDP_OP_XOR: logic_result = (dest_operand ^ src_operand) & mask;
            ALIDP_OP_INVERT: logic_result = ~dest_operand & mask;
            default: logic_result = diff_res;
        endcase
    end

endmodule : alidp_logic_unit

// ===== design/alidp_multiplier.sv
// Combinational byte or word multiplier, unsigned or signed.
`timescale 1ns/100ps
module alidp_multiplier
(
    // Mode.
    input wire logic word_size,
    input wire logic signed_mode,
    // Operands.
    input wire logic [15:0] mult_a,
    input wire logic [15:0] mult_b,
    // Product.
    output logic [31:0] product
);
    logic [16:0] a_ext;
    logic [16:0] b_ext;
    logic [33:0] full;

    // Extends an operand to 17 bits at the selected width and signedness.
    function automatic logic [16:0] extend(input logic wsize, input logic sgn,
                                           input logic [15:0] v);
        return wsize ? {sgn & v[15], v} : {{9{sgn & v[7]}}, v[7:0]};
    endfunction : extend

    // Signed product of seventeen-bit operands covers both unsigned and signed operands.
    assign a_ext = extend(word_size, signed_mode, mult_a);
    assign b_ext = extend(word_size, signed_mode, mult_b);
    assign full = 34'($signed(a_ext) * $signed(b_ext));
    assign product = full[31:0];

endmodule : alidp_multiplier

// ===== design/alidp_pkg.sv
// Shared constants, types and helper functions of the integer instruction datapath.
// Function
// - Unsigned multiply writes destination times source back into the destination.
// - Negate replaces the destination with zero minus its value.
// - Sum of products multiplies fetched operand pairs into the 32-bit accumulator pair.
// - Subtract with borrow stores destination minus source minus inverted carry.
// - Plain subtract stores destination minus source, carry not used as borrow.
// - Logical AND writes source AND destination into the destination.
// - Invert complements every destination bit and writes it back.
// - Logical OR writes source OR destination into the destination.
// - Test forms source AND destination for flags only, destination unchanged.
// - Exclusive OR writes destination XOR source into the destination.
package alidp_pkg;

    // Widths of data, accumulator and memory addresses.
    localparam int ALIDP_DATA_W = 16;
    localparam int ALIDP_ACC_W = 32;
    localparam int ALIDP_ADDR_W = 20;

    // Pointer advance per element for byte and word operands.
    localparam logic [19:0] ALIDP_BYTE_STEP = 20'h00001;
    localparam logic [19:0] ALIDP_WORD_STEP = 20'h00002;

    // Reset values of data, accumulator, pointer and flag registers.
    localparam logic [15:0] ALIDP_RST_DATA = 16'h0000;
    localparam logic [31:0] ALIDP_RST_ACC = 32'h00000000;
    localparam logic [19:0] ALIDP_RST_PTR = 20'h00000;
    localparam logic [3:0] ALIDP_RST_FLAGS = 4'h0;

    // Bit positions in the flag and flag-write vectors.
    localparam int ALIDP_FLAG_C = 0;
    localparam int ALIDP_FLAG_Z = 1;
    localparam int ALIDP_FLAG_S = 2;
    localparam int ALIDP_FLAG_O = 3;

    // Flag-write masks per instruction class.
    localparam logic [3:0] ALIDP_WE_NONE = 4'h0;
    localparam logic [3:0] ALIDP_WE_SZ = 4'h6;
    localparam logic [3:0] ALIDP_WE_ALL = 4'hF;
    localparam logic [3:0] ALIDP_WE_O = 4'h8;

    // Instructions handled by the datapath.
    typedef enum logic [3:0] {
        ALIDP_OP_UNSIGNED_MULTIPLY,
        ALIDP_OP_NEGATE_OP,
        ALIDP_OP_SUM_OF_PRODUCTS,
        ALIDP_OP_SUBTRACT_WITH_BORROW,
        ALIDP_OP_SUBTRACT,
        ALIDP_OP_AND,
        ALIDP_OP_INVERT,
        ALIDP_OP_OR,
        ALIDP_OP_BITWISE_TEST,
        ALIDP_OP_XOR
    } alidp_op_t;

    // Sequencer states.
    typedef enum logic [2:0] {
        ALIDP_ST_IDLE,
        ALIDP_ST_CHECK,
        ALIDP_ST_FETCH_A,
        ALIDP_ST_FETCH_B,
        ALIDP_ST_ACCUM,
        ALIDP_ST_FINISH
    } alidp_state_t;

    // Mask that keeps the bits of the selected operand width.
    function automatic logic [15:0] alidp_mask(input logic word_size);
        return word_size ? 16'hFFFF : 16'h00FF;
    endfunction : alidp_mask

    // Most significant bit of a value at the selected width.
    function automatic logic alidp_msb(input logic word_size, input logic [15:0] value);
        return word_size ? value[15] : value[7];
    endfunction : alidp_msb

endpackage : alidp_pkg

// ===== design/alidp_top.sv
// Execution datapath for multiply, negate, sum of products, subtract and logic instructions.
`timescale 1ns/100ps
module alidp_top
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Instruction request from the decoder.
    input wire logic start,
    input alidp_pkg::alidp_op_t op,
    input wire logic word_size,
    input wire logic [15:0] src_operand,
    input wire logic [15:0] dest_operand,
    input wire logic carry_in,
    // Sum-of-products register values at start.
    input wire logic [19:0] multiplicand_pointer_in,
    input wire logic [19:0] multiplier_pointer_in,
    input wire logic [15:0] repeat_count_in,
    input wire logic [31:0] accumulator_in,
    // Operand memory port.
    output logic mem_req,
    output logic [19:0] mem_addr,
    output logic mem_word,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    // Results to the register file.
    output logic busy,
    output logic done,
    output logic dest_write,
    output logic [15:0] result,
    output logic [15:0] result_high,
    output logic result_wide,
    output logic [3:0] flags,
    output logic [3:0] flags_we,
    output logic [31:0] accumulator_pair,
    output logic [19:0] multiplicand_pointer,
    output logic [19:0] multiplier_pointer,
    output logic [15:0] repeat_count_register
);
    import alidp_pkg::*;

    alidp_state_t state;
    alidp_state_t next_state;
    logic sump_word;
    logic [15:0] operand_a;
    logic [15:0] operand_b;
    logic acc_overflow;

    logic take;
    logic is_sump;
    logic is_unsigned_multiply;
    logic is_arith;
    logic [15:0] logic_result;
    logic logic_carry;
    logic logic_ovf;
    logic mult_word;
    logic mult_signed;
    logic [15:0] mult_a;
    logic [15:0] mult_b;
    logic [31:0] product;
    logic [31:0] acc_sum;
    logic acc_step_ovf;
    logic [19:0] ptr_step;
    logic [15:0] single_result;
    logic [15:0] single_high;
    logic [3:0] single_flags;
    logic [3:0] single_we;
    logic [15:0] fetched;

    // Request decoding.
    assign take = start && (state == ALIDP_ST_IDLE);
    assign is_sump = (op == ALIDP_OP_SUM_OF_PRODUCTS);
    assign is_unsigned_multiply = (op == ALIDP_OP_UNSIGNED_MULTIPLY);
    assign is_arith = (op == ALIDP_OP_NEGATE_OP) || (op == ALIDP_OP_SUBTRACT)
        || (op == ALIDP_OP_SUBTRACT_WITH_BORROW);

    // Subtract, negate and bitwise logic.
    alidp_logic_unit u_logic
    (
        .op(op),
        .word_size(word_size),
        .src_operand(src_operand),
        .dest_operand(dest_operand),
        .carry_in(carry_in),
        .logic_result(logic_result),
        .carry_out(logic_carry),
        .overflow_out(logic_ovf)
    );

    // The multiplier serves the unsigned multiply when idle and the products otherwise.
    assign mult_word = (state == ALIDP_ST_IDLE) ? word_size : sump_word;
    assign mult_signed = (state != ALIDP_ST_IDLE);
    assign mult_a = (state == ALIDP_ST_IDLE) ? dest_operand : operand_a;
    assign mult_b = (state == ALIDP_ST_IDLE) ? src_operand : operand_b;

    alidp_multiplier u_mult
    (
        .word_size(mult_word),
        .signed_mode(mult_signed),
        .mult_a(mult_a),
        .mult_b(mult_b),
        .product(product)
    );

    // Accumulation with signed overflow detection.
    assign acc_sum = accumulator_pair + product;
    assign acc_step_ovf = (accumulator_pair[31] == product[31]) && (acc_sum[31] != product[31]);
    assign ptr_step = sump_word ? ALIDP_WORD_STEP : ALIDP_BYTE_STEP;
    assign fetched = sump_word ? mem_rdata : {8'h00, mem_rdata[7:0]};

    // Result of a single-cycle instruction, word product split into low and high halves.
    assign single_result = is_unsigned_multiply ? (word_size ? product[15:0] : product[15:0])
        : logic_result;
    assign single_high = (is_unsigned_multiply && word_size) ? product[31:16] : ALIDP_RST_DATA;

    // Flags of a single-cycle instruction at the selected width.
    assign single_flags[ALIDP_FLAG_C] = logic_carry;
    assign single_flags[ALIDP_FLAG_Z] = ((logic_result & alidp_mask(word_size)) == 16'h0000);
    assign single_flags[ALIDP_FLAG_S] = alidp_msb(word_size, logic_result);
    assign single_flags[ALIDP_FLAG_O] = logic_ovf;
    assign single_we = is_unsigned_multiply ? ALIDP_WE_NONE : (is_arith ? ALIDP_WE_ALL : ALIDP_WE_SZ);

    // Sequencer for the sum of products.
    always_comb
    begin
        next_state = state;
        case (state)
            ALIDP_ST_IDLE:
            begin
                if (take && is_sump)
                    next_state = ALIDP_ST_CHECK;
            end
            ALIDP_ST_CHECK:
            begin
                if (repeat_count_register == 16'h0000)
                    next_state = ALIDP_ST_FINISH;
                else
                    next_state = ALIDP_ST_FETCH_A;
            end
            ALIDP_ST_FETCH_A:
            begin
                if (mem_ack)
                    next_state = ALIDP_ST_FETCH_B;
            end
            ALIDP_ST_FETCH_B:
            begin
                if (mem_ack)
                    next_state = ALIDP_ST_ACCUM;
            end
            ALIDP_ST_ACCUM:
                next_state = ALIDP_ST_CHECK;
            ALIDP_ST_FINISH:
                next_state = ALIDP_ST_IDLE;
            default:
                next_state = ALIDP_ST_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state <= ALIDP_ST_IDLE;
        else
            state <= next_state;
    end

    // Memory request follows the fetch states, address from the active pointer.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mem_req <= 1'b0;
            mem_addr <= ALIDP_RST_PTR;
        end
        else
        begin
            mem_req <= (next_state == ALIDP_ST_FETCH_A) || (next_state == ALIDP_ST_FETCH_B);
            mem_addr <= (next_state == ALIDP_ST_FETCH_B) ? multiplier_pointer
                : multiplicand_pointer;
        end
    end

    // Fetched operands of one product.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            operand_a <= ALIDP_RST_DATA;
            operand_b <= ALIDP_RST_DATA;
        end
        else
        begin
            if (state == ALIDP_ST_FETCH_A && mem_ack)
                operand_a <= fetched;
            if (state == ALIDP_ST_FETCH_B && mem_ack)
                operand_b <= fetched;
        end
    end

    // Sum-of-products working registers: pointers, count, accumulator, width.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sump_word <= 1'b0;
            mem_word <= 1'b0;
            multiplicand_pointer <= ALIDP_RST_PTR;
            multiplier_pointer <= ALIDP_RST_PTR;
            repeat_count_register <= ALIDP_RST_DATA;
            accumulator_pair <= ALIDP_RST_ACC;
            acc_overflow <= 1'b0;
        end
        else if (take && is_sump)
        begin
            sump_word <= word_size;
            mem_word <= word_size;
            multiplicand_pointer <= multiplicand_pointer_in;
            multiplier_pointer <= multiplier_pointer_in;
            repeat_count_register <= repeat_count_in;
            accumulator_pair <= accumulator_in;
            acc_overflow <= 1'b0;
        end
        else if (state == ALIDP_ST_ACCUM)
        begin
            accumulator_pair <= acc_sum;
            acc_overflow <= acc_overflow | acc_step_ovf;
            multiplicand_pointer <= multiplicand_pointer + ptr_step;
            multiplier_pointer <= multiplier_pointer + ptr_step;
            repeat_count_register <= repeat_count_register - 16'h0001;
        end
    end

    // Completion, write-back and flags of every instruction.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            dest_write <= 1'b0;
            result <= ALIDP_RST_DATA;
            result_high <= ALIDP_RST_DATA;
            result_wide <= 1'b0;
            flags <= ALIDP_RST_FLAGS;
            flags_we <= ALIDP_WE_NONE;
        end
        else
        begin
            busy <= (next_state != ALIDP_ST_IDLE) && (next_state != ALIDP_ST_FINISH);
            done <= (take && !is_sump) || (state == ALIDP_ST_FINISH);
            dest_write <= take && !is_sump && (op != ALIDP_OP_BITWISE_TEST);
            flags_we <= ALIDP_WE_NONE;
            if (take && !is_sump)
            begin
                result <= single_result;
                result_high <= single_high;
                result_wide <= is_unsigned_multiply && word_size;
                flags <= single_flags;
                flags_we <= single_we;
            end
            else if (state == ALIDP_ST_FINISH)
            begin
                result_wide <= 1'b0;
                flags[ALIDP_FLAG_O] <= acc_overflow;
                flags_we <= ALIDP_WE_O;
            end
        end
    end

endmodule : alidp_top

// ===== test/alidp_mem_model.sv
// Operand memory that answers each fetch after a chosen number of wait cycles.
`timescale 1ns/100ps
module alidp_mem_model
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Wait cycles before each acknowledge.
    input wire logic [3:0] wait_cycles,
    // Fetch port.
    input wire logic mem_req,
    input wire logic [19:0] mem_addr,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [3:0] cnt;
    // One pulse per fetch; outside it the data lines invert their value every cycle.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt <= 4'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
        end
        else if (mem_req && !mem_ack && cnt == wait_cycles)
        begin
            cnt <= 4'h0;
            mem_ack <= 1'b1;
            mem_rdata <= mem_addr[15:0] ^ 16'hA5C3;
        end
        else
        begin
            cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : alidp_mem_model

// ===== test/alidp_top_assertions.sv
// Concurrent checks on the ports of the datapath.
`timescale 1ns/100ps
module alidp_top_assertions
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Request.
    input wire logic start,
    input alidp_pkg::alidp_op_t op,
    input wire logic word_size,
    input wire logic [15:0] src_operand,
    input wire logic [15:0] dest_operand,
    input wire logic carry_in,
    input wire logic [15:0] repeat_count_in,
    input wire logic [31:0] accumulator_in,
    // Memory port and results.
    input wire logic mem_req,
    input wire logic [19:0] mem_addr,
    input wire logic mem_ack,
    input wire logic busy,
    input wire logic done,
    input wire logic dest_write,
    input wire logic [15:0] result,
    input wire logic [15:0] result_high,
    input wire logic [31:0] accumulator_pair
);
    import alidp_pkg::*;
    logic busy_d;
    // Busy of the previous cycle marks the finish cycle, in which a request is refused.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            busy_d <= 1'b0;
        else
            busy_d <= busy;
    end
    // Accepted request and operands cut to the selected width.
    wire logic take = start && !busy && !busy_d;
    wire logic [15:0] m = word_size ? 16'hFFFF : 16'h00FF;
    wire logic [15:0] s = src_operand & m;
    wire logic [15:0] d = dest_operand & m;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // A single-cycle request accepted with the given operation.
    sequence s_take(alidp_op_t o);
        take && op == o;
    endsequence
    // A sum of products accepted with nothing to repeat.
    sequence s_sop_empty;
        take && op == ALIDP_OP_SUM_OF_PRODUCTS && repeat_count_in == 16'h0000;
    endsequence
    // The written result follows its request by one cycle.
    property p_res(alidp_op_t o, logic [15:0] v);
        s_take(o) |=> done && dest_write && result == $past(v);
    endproperty
    a_and_result: assert property (p_res(ALIDP_OP_AND, s & d)) else $error("and wrong");
    a_or_result: assert property (p_res(ALIDP_OP_OR, s | d)) else $error("or wrong");
    a_xor_result: assert property (p_res(ALIDP_OP_XOR, s ^ d)) else $error("xor wrong");
    a_not_result: assert property (p_res(ALIDP_OP_INVERT, ~d & m)) else $error("inv wrong");
    a_neg_result: assert property (p_res(ALIDP_OP_NEGATE_OP, (16'h0000 - d) & m))
        else $error("negate wrong");
    a_sub_result: assert property (p_res(ALIDP_OP_SUBTRACT, (d - s) & m))
        else $error("subtract wrong");
    a_sbb_result: assert property (p_res(ALIDP_OP_SUBTRACT_WITH_BORROW,
        (d - s - {15'h0000, ~carry_in}) & m)) else $error("borrow subtract wrong");
    a_test_nowrite: assert property (s_take(ALIDP_OP_BITWISE_TEST) |=> done && !dest_write)
        else $error("test wrote destination");
    a_unsigned_multiply_word: assert property (take && op == ALIDP_OP_UNSIGNED_MULTIPLY && word_size
        |=> {result_high, result} == $past({16'h0000, s} * {16'h0000, d})) else $error("mul wrong");
    a_sop_empty: assert property (s_sop_empty |-> ##3 (done &&
        accumulator_pair == $past(accumulator_in, 3))) else $error("empty sum wrong");
    a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("fetch dropped");
    a_req_busy: assert property (mem_req |-> busy) else $error("fetch while idle");
endmodule : alidp_top_assertions

// ===== test/alidp_top_tb.sv
// Self-checking bench of the datapath with its operand memory.
`timescale 1ns/100ps
module alidp_top_tb;
    import alidp_pkg::*;
    logic clk, resetn, start, word_size, carry_in, mem_req, mem_word, mem_ack, busy, done;
    logic dest_write, result_wide;
    alidp_op_t op;
    logic [15:0] src_operand, dest_operand, cnt_in, mem_rdata, result, result_high, rcr;
    logic [19:0] mcp_in, mlp_in, mem_addr, mcp, mlp;
    logic [31:0] acc_in, accumulator_pair;
    logic [3:0] wait_cycles, flags, flags_we;
    int n_fail, n_tests;
    alidp_top DUT (.clk(clk), .resetn(resetn), .start(start), .op(op), .word_size(word_size),
        .src_operand(src_operand), .dest_operand(dest_operand), .carry_in(carry_in),
        .multiplicand_pointer_in(mcp_in), .multiplier_pointer_in(mlp_in),
        .repeat_count_in(cnt_in), .accumulator_in(acc_in), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_word(mem_word), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .busy(busy), .done(done), .dest_write(dest_write), .result(result),
        .result_high(result_high), .result_wide(result_wide), .flags(flags),
        .flags_we(flags_we), .accumulator_pair(accumulator_pair),
        .multiplicand_pointer(mcp), .multiplier_pointer(mlp), .repeat_count_register(rcr));
    alidp_mem_model u_mem (.clk(clk), .resetn(resetn), .wait_cycles(wait_cycles),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    // Compares one value and counts it.
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_tests++;
        if (seen !== expd)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expd);
        end
    endtask : check
    // Memory contents as the operand memory serves them.
    function automatic logic [15:0] mdat(input logic [19:0] a);
        return a[15:0] ^ 16'hA5C3;
    endfunction : mdat
    // Expected product or result of a single-cycle operation.
    function automatic logic [31:0] exp_res(input alidp_op_t o, input logic ws,
        input logic [15:0] a, input logic [15:0] b, input logic c);
        logic [15:0] m;
        logic [15:0] s;
        logic [15:0] d;
        m = ws ? 16'hFFFF : 16'h00FF;
        s = a & m;
        d = b & m;
        case (o)
            ALIDP_OP_UNSIGNED_MULTIPLY: return {16'h0000, s} * {16'h0000, d};
            ALIDP_OP_NEGATE_OP: return {16'h0000, (16'h0000 - d) & m};
            ALIDP_OP_SUBTRACT_WITH_BORROW: return {16'h0000, (d - s - {15'h0000, ~c}) & m};
            ALIDP_OP_SUBTRACT: return {16'h0000, (d - s) & m};
            ALIDP_OP_INVERT: return {16'h0000, ~d & m};
            ALIDP_OP_OR: return {16'h0000, s | d};
            ALIDP_OP_XOR: return {16'h0000, s ^ d};
            default: return {16'h0000, s & d};
        endcase
    endfunction : exp_res
    // Flag bits that each operation updates.
    function automatic logic [3:0] exp_we(input alidp_op_t o);
        if (o == ALIDP_OP_UNSIGNED_MULTIPLY)
            return ALIDP_WE_NONE;
        if (o == ALIDP_OP_NEGATE_OP || o == ALIDP_OP_SUBTRACT || o == ALIDP_OP_SUBTRACT_WITH_BORROW)
            return ALIDP_WE_ALL;
        return ALIDP_WE_SZ;
    endfunction : exp_we
    // Every single-cycle operation at both widths, issued back to back.
    task automatic run_single();
        logic [15:0] sv [3] = '{16'hF0F0, 16'h00FF, 16'hFFFF};
        logic [15:0] dv [3] = '{16'h0F0F, 16'hFF01, 16'hFFFF};
        alidp_op_t o;
        alidp_op_t po;
        logic [31:0] e;
        logic [31:0] pe;
        logic pw;
        int k;
        for (int i = 0; i <= 54; i++)
        begin
            @(posedge clk);
            k = i % 3;
            o = alidp_op_t'((i / 6 >= 2) ? i / 6 + 1 : i / 6);
            e = exp_res(o, (i / 3) % 2, sv[k], dv[k], k != 0);
            start <= i < 54;
            op <= o;
            word_size <= (i / 3) % 2;
            src_operand <= sv[k];
            dest_operand <= dv[k];
            carry_in <= k != 0;
            #1;
            if (i > 0)
            begin
                check(done, 1'b1);
                check(dest_write, po != ALIDP_OP_BITWISE_TEST);
                check(result, pe[15:0]);
                check(flags_we, exp_we(po));
                check(result_wide, po == ALIDP_OP_UNSIGNED_MULTIPLY && pw);
                if (po == ALIDP_OP_UNSIGNED_MULTIPLY)
                    check(result_high, pe[31:16]);
                if (exp_we(po) != ALIDP_WE_NONE)
                begin
                    check(flags[ALIDP_FLAG_Z], pe[15:0] == 16'h0000);
                    check(flags[ALIDP_FLAG_S], pw ? pe[15] : pe[7]);
                end
            end
            po = o;
            pe = e;
            pw = (i / 3) % 2;
        end
    endtask : run_single
    // Sum of products over n elements, with a refused request while it runs when n is nonzero.
    task automatic run_sop(input logic ws, input logic [15:0] n, input logic [3:0] w);
        logic [31:0] acc;
        logic [19:0] step;
        logic [15:0] a;
        logic [15:0] b;
        int t;
        step = ws ? ALIDP_WORD_STEP : ALIDP_BYTE_STEP;
        acc = 32'h00012345;
        for (int k = 0; k < n; k++)
        begin
            a = mdat(20'h01000 + step * 20'(k));
            b = mdat(20'h02000 + step * 20'(k));
            acc = acc + (ws ? {{16{a[15]}}, a} * {{16{b[15]}}, b}
                : {{24{a[7]}}, a[7:0]} * {{24{b[7]}}, b[7:0]});
        end
        @(posedge clk);
        wait_cycles <= w;
        start <= 1'b1;
        op <= ALIDP_OP_SUM_OF_PRODUCTS;
        word_size <= ws;
        mcp_in <= 20'h01000;
        mlp_in <= 20'h02000;
        cnt_in <= n;
        acc_in <= 32'h00012345;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        start <= n != 16'h0000;
        op <= ALIDP_OP_AND;
        t = 0;
        do
        begin
            @(posedge clk);
            start <= 1'b0;
            #1;
            t++;
        end
        while (done !== 1'b1 && t < 200);
        check(t < 200, 1'b1);
        check(accumulator_pair, acc);
        check(mem_word, ws);
        check(mcp, 20'h01000 + step * 20'(n));
        check(mlp, 20'h02000 + step * 20'(n));
        check(rcr, 16'h0000);
        check({dest_write, flags_we}, {1'b0, ALIDP_WE_O});
    endtask : run_sop
    // Reset in the middle of a sum of products clears the live registers.
    task automatic run_reset();
        @(posedge clk);
        start <= 1'b1;
        op <= ALIDP_OP_SUM_OF_PRODUCTS;
        cnt_in <= 16'h0004;
        @(posedge clk);
        start <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        check({busy, mem_req}, 2'h0);
        check(accumulator_pair, 32'h0);
        resetn <= 1'b1;
    endtask : run_reset
    // Prints the verdict and ends the run.
    task automatic summarize();
        if (n_fail == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    // Core clock.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Main sequence.
    initial
    begin
        {n_fail, n_tests, resetn, start, word_size, carry_in} = '0;
        {src_operand, dest_operand, cnt_in, mcp_in, mlp_in, acc_in, wait_cycles} = '0;
        op = ALIDP_OP_AND;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        run_single();
        run_sop(1'b1, 16'h0000, 4'h0);
        run_sop(1'b1, 16'h0003, 4'h0);
        run_sop(1'b0, 16'h0002, 4'h2);
        run_reset();
        run_sop(1'b1, 16'h0001, 4'h1);
        summarize();
    end
    // Watchdog against a hang.
    initial
    begin
        #40000;
        n_fail++;
        summarize();
    end
endmodule : alidp_top_tb
bind alidp_top alidp_top_assertions u_chk (.clk(clk), .resetn(resetn), .start(start), .op(op),
    .word_size(word_size), .src_operand(src_operand), .dest_operand(dest_operand),
    .carry_in(carry_in), .repeat_count_in(repeat_count_in), .accumulator_in(accumulator_in),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .busy(busy), .done(done),
    .dest_write(dest_write), .result(result), .result_high(result_high),
    .accumulator_pair(accumulator_pair));
